// file: uic_pkg.sv
// package: register codes, field positions, reset values and timing for the uart interrupt block
package uic_pkg;

	// ------------------------------------------------------------
	// register selects on the parallel port
	// ------------------------------------------------------------
	localparam logic [2:0] REG_RX_TX   = 3'h0;
	localparam logic [2:0] REG_IEN     = 3'h1;
	localparam logic [2:0] REG_ISR_FCR = 3'h2;
	localparam logic [2:0] REG_LSR     = 3'h5;
	localparam logic [2:0] REG_MSR     = 3'h6;

	// ------------------------------------------------------------
	// interrupt enable fields
	// ------------------------------------------------------------
	localparam int IE_RX    = 0;
	localparam int IE_TX    = 1;
	localparam int IE_LINE  = 2;
	localparam int IE_MODEM = 3;
	localparam int IE_SLEEP = 4;
	localparam int IE_XOFF  = 5;
	localparam int IE_RTS   = 6;
	localparam int IE_CTS   = 7;
	localparam logic [7:0] IEN_RESET = 8'h00;

	// ------------------------------------------------------------
	// fifo control fields
	// ------------------------------------------------------------
	localparam int FC_EN    = 0;
	localparam int FC_RXRST = 1;
	localparam int FC_TXRST = 2;
	localparam int FC_DMA   = 3;
	localparam int FC_TXTRG = 4;
	localparam int FC_RXTRG = 6;
	localparam logic [1:0] TRIG_RESET = 2'h0;

	// ------------------------------------------------------------
	// interrupt status codes, bits 5..0
	// ------------------------------------------------------------
	localparam logic [5:0] CODE_LINE  = 6'h06;
	localparam logic [5:0] CODE_TOUT  = 6'h0C;
	localparam logic [5:0] CODE_RECEIVE_READY_PIN = 6'h04;
	localparam logic [5:0] CODE_TRANSMIT_READY_PIN = 6'h02;
	localparam logic [5:0] CODE_MODEM = 6'h00;
	localparam logic [5:0] CODE_XOFF  = 6'h10;
	localparam logic [5:0] CODE_FLOW  = 6'h20;
	localparam logic [5:0] CODE_NONE  = 6'h01;

	// ------------------------------------------------------------
	// receive time-out: four characters plus twelve bits, in bit times
	// ------------------------------------------------------------
	localparam int TOUT_CHARS = 4;
	localparam int TOUT_BITS  = 12;

	// trigger level for a two-bit select
	function automatic logic [4:0] trig_level(input logic [1:0] sel);
		unique case (sel)
			2'h0: trig_level = 5'h01;
			2'h1: trig_level = 5'h04;
			2'h2: trig_level = 5'h08;
			2'h3: trig_level = 5'h0E;
		endcase
	endfunction

endpackage

// file: uic_timeout.sv
// receive time-out timer counted in bit ticks
`timescale 1ns/10ps
module uic_timeout #(
	parameter int CW = 8
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          resetn,
	// control
	input  wire logic          bit_tick,
	input  wire logic          restart,
	input  wire logic          armed,
	input  wire logic [3:0]    char_bits,
	// result
	output logic               expired
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          exp;
	} uic_to_state_t;

	uic_to_state_t s_q, s_d;
	logic [CW-1:0] limit;

	// four character times plus twelve bit times
	assign limit = CW'(uic_pkg::TOUT_CHARS * char_bits + uic_pkg::TOUT_BITS);

	always_comb begin
		s_d = s_q;
		if (restart || !armed) begin
			s_d.cnt = '0;
			s_d.exp = 1'b0;
		end else if (bit_tick && !s_q.exp) begin
			s_d.cnt = s_q.cnt + CW'(1);
			if (s_q.cnt + CW'(1) >= limit)
				s_d.exp = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign expired = s_q.exp;
endmodule // uic_timeout

// file: uic_ctrl.sv
// interrupt enable, prioritised interrupt status and fifo control of one uart channel
// Notes on behaviour
// - receive-data enable raises interrupt on held character or fifo reaching trigger
// - transmit-ready fires on empty holder or below trigger; enabling while empty fires
// - overrun interrupts on receipt; parity, framing, break when faulty character read out
// - all eight interrupt enable bits reset to zero
// - upper four enable bits act only while enhanced bit 4 is set
// - rising edges of request-to-send output and clear-to-send input interrupt under auto flow
// - status read returns highest pending code; lower ones stay queued, except xoff and special, which any status read clears
// - codes: line 000110, time-out 001100, data ready 000100, transmit 000010
// - codes: modem 000000, xoff/special 010000, flow 100000, none 000001
// - time-out timer spans four characters plus twelve bit times
// - line clears on line status read, ready below trigger, time-out on receive read
// - transmit-ready clears on a status read that reports it or on transmit holding write
// - modem bits 0-3 raise modem interrupt; modem status read clears it and flow
// - xoff clears on status read or xon; special on status read or next character
// - status bit 0 reads 0 while pending, 1 when idle and at reset
// - status bits 7:6 read 11 with fifos enabled, 00 otherwise
// - status bits 4 and 5 active only while enhanced bit 4 set
// - fifo control bit 0 enables fifos; other bits ignored unless bit 0 set
// - receive fifo reset clears its pointers only, bit self-clears
// - transmit fifo reset clears its pointers only, bit self-clears
// - fifo control bit 3 selects dma mode for ready pins, default normal
// - transmit trigger from bits 5:4 only while enhanced bit 4 set, empty if last reload never passed trigger
// - trigger selects 00,01,10,11 give 1,4,8,14 characters
`timescale 1ns/10ps
module uic_ctrl #(
	parameter int FIFO_DEPTH = 16,
	parameter int TOUT_CW    = 8
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// parallel register port
	input  wire logic [2:0] addr,
	input  wire logic       rd,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	// enhanced function and flow config
	input  wire logic       enh_en,
	input  wire logic       auto_rts,
	input  wire logic       auto_cts,
	// receive path status
	input  wire logic [4:0] rx_count,
	input  wire logic       rx_char_in,
	input  wire logic       overrun,
	input  wire logic       head_error,
	input  wire logic       bit_tick,
	input  wire logic [3:0] char_bits,
	// transmit path status
	input  wire logic [4:0] tx_count,
	// modem and flow lines
	input  wire logic [3:0] modem_delta,
	input  wire logic       rts_out,
	input  wire logic       cts_in,
	// software flow detection
	input  wire logic       xoff_seen,
	input  wire logic       xon_seen,
	input  wire logic       special_seen,
	// control outputs
	output logic            irq,
	output logic            fifo_en,
	output logic            dma_mode,
	output logic            sleep_en,
	output logic            rx_fifo_reset,
	output logic            tx_fifo_reset,
	output logic      [4:0] rx_trigger,
	output logic      [4:0] tx_trigger,
	// ready pins, active low
	output logic            receive_ready_pin_n,
	output logic            transmit_ready_pin_n
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ien;
		logic       fen;
		logic       dma;
		logic [1:0] rxsel;
		logic [1:0] txsel;
		logic       rxrst;
		logic       txrst;
		logic       line_p;
		logic       tx_p;
		logic       modem_p;
		logic       xoff_p;
		logic       spec_p;
		logic       flow_p;
		logic       rts_prev;
		logic       cts_prev;
		logic       tx_over;
		logic       tx_empty_prev;
		logic [5:0] latched;
	} uic_state_t;

	uic_state_t s_q, s_d;

	logic       tout;
	logic       rd_rx, wr_tx, rd_isr, wr_fcr, wr_ien, rd_lsr, rd_msr;
	logic       rx_src, tout_src, tx_below, tx_empty;
	logic       line_act, rx_act, tout_act, tx_act, modem_act, xoff_act, flow_act;
	logic [5:0] code;
	logic [4:0] rx_trig, tx_trig;

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	assign rd_rx  = rd && addr == uic_pkg::REG_RX_TX;
	assign wr_tx  = wr && addr == uic_pkg::REG_RX_TX;
	assign wr_ien = wr && addr == uic_pkg::REG_IEN;
	assign rd_isr = rd && addr == uic_pkg::REG_ISR_FCR;
	assign wr_fcr = wr && addr == uic_pkg::REG_ISR_FCR;
	assign rd_lsr = rd && addr == uic_pkg::REG_LSR;
	assign rd_msr = rd && addr == uic_pkg::REG_MSR;

	assign rx_trig = uic_pkg::trig_level(s_q.rxsel);
	assign tx_trig = uic_pkg::trig_level(s_q.txsel);

	// ------------------------------------------------------------
	// receive time-out
	// ------------------------------------------------------------
	uic_timeout #(
		.CW(TOUT_CW)
	) u_tout (
		.clock     (clock),
		.resetn    (resetn),
		.bit_tick  (bit_tick),
		.restart   (rx_char_in || rd_rx),
		.armed     (s_q.fen && rx_count != 5'h00),
		.char_bits (char_bits),
		.expired   (tout)
	);

	// ------------------------------------------------------------
	// sources
	// ------------------------------------------------------------
	assign rx_src   = s_q.fen ? (rx_count >= rx_trig) : (rx_count != 5'h00);
	assign tout_src = tout;
	assign tx_empty = tx_count == 5'h00;
	// below trigger only if the last reload passed it; else wait for empty
	assign tx_below = s_q.fen ? (s_q.tx_over ? tx_count < tx_trig : tx_empty)
		: tx_empty;

	assign line_act  = s_q.ien[uic_pkg::IE_LINE]  && s_q.line_p;
	assign tout_act  = s_q.ien[uic_pkg::IE_RX]    && tout_src;
	assign rx_act    = s_q.ien[uic_pkg::IE_RX]    && rx_src;
	assign tx_act    = s_q.ien[uic_pkg::IE_TX]    && s_q.tx_p;
	assign modem_act = s_q.ien[uic_pkg::IE_MODEM] && s_q.modem_p;
	assign xoff_act  = enh_en && s_q.ien[uic_pkg::IE_XOFF]
		&& (s_q.xoff_p || s_q.spec_p);
	assign flow_act  = enh_en && s_q.flow_p;

	// priority encoder
	always_comb begin
		if (line_act)       code = uic_pkg::CODE_LINE;
		else if (tout_act)  code = uic_pkg::CODE_TOUT;
		else if (rx_act)    code = uic_pkg::CODE_RECEIVE_READY_PIN;
		else if (tx_act)    code = uic_pkg::CODE_TRANSMIT_READY_PIN;
		else if (modem_act) code = uic_pkg::CODE_MODEM;
		else if (xoff_act)  code = uic_pkg::CODE_XOFF;
		else if (flow_act)  code = uic_pkg::CODE_FLOW;
		else                code = uic_pkg::CODE_NONE;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rxrst = 1'b0;
		s_d.txrst = 1'b0;
		s_d.rts_prev = rts_out;
		s_d.cts_prev = cts_in;
		s_d.tx_empty_prev = tx_below;

		if (wr_ien) begin
			s_d.ien[3:0] = wdata[3:0];
			if (enh_en)
				s_d.ien[7:4] = wdata[7:4];
			// enabling while already empty fires at once
			if (wdata[uic_pkg::IE_TX] && !s_q.ien[uic_pkg::IE_TX] && tx_below)
				s_d.tx_p = 1'b1;
		end

		if (wr_fcr) begin
			s_d.fen = wdata[uic_pkg::FC_EN];
			if (wdata[uic_pkg::FC_EN]) begin
				s_d.rxrst = wdata[uic_pkg::FC_RXRST];
				s_d.txrst = wdata[uic_pkg::FC_TXRST];
				s_d.dma   = wdata[uic_pkg::FC_DMA];
				s_d.rxsel = wdata[uic_pkg::FC_RXTRG +: 2];
				if (enh_en)
					s_d.txsel = wdata[uic_pkg::FC_TXTRG +: 2];
			end
		end

		// transmit reload tracking: did the fifo pass its trigger
		if (tx_empty)
			s_d.tx_over = 1'b0;
		else if (tx_count > tx_trig)
			s_d.tx_over = 1'b1;

		// clears first, sets after so a coincident event wins
		if (rd_lsr)
			s_d.line_p = 1'b0;
		if (rd_isr && code == uic_pkg::CODE_TRANSMIT_READY_PIN || wr_tx)
			s_d.tx_p = 1'b0;
		if (rd_msr) begin
			s_d.modem_p = 1'b0;
			s_d.flow_p  = 1'b0;
		end
		if (rd_isr || xon_seen)
			s_d.xoff_p = 1'b0;
		if (rd_isr || (rx_char_in && s_q.spec_p && !special_seen))
			s_d.spec_p = 1'b0;

		if (overrun || (rd_rx && head_error))
			s_d.line_p = 1'b1;
		if (tx_below && !s_q.tx_empty_prev)
			s_d.tx_p = 1'b1;
		if (|modem_delta)
			s_d.modem_p = 1'b1;
		if (xoff_seen)
			s_d.xoff_p = 1'b1;
		if (special_seen)
			s_d.spec_p = 1'b1;
		if ((auto_rts && s_q.ien[uic_pkg::IE_RTS] && rts_out && !s_q.rts_prev)
			|| (auto_cts && s_q.ien[uic_pkg::IE_CTS] && cts_in && !s_q.cts_prev))
			s_d.flow_p = 1'b1;

		// record the code reported by a status read in latched
		if (rd_isr)
			s_d.latched = code;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_q         <= '0;
			s_q.ien     <= uic_pkg::IEN_RESET;
			s_q.rxsel   <= uic_pkg::TRIG_RESET;
			s_q.txsel   <= uic_pkg::TRIG_RESET;
			s_q.latched <= uic_pkg::CODE_NONE;
			// fifo starts empty: no false transmit edge after reset
			s_q.tx_empty_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		rdata = 8'h00;
		unique case (addr)
			uic_pkg::REG_IEN:     rdata = s_q.ien;
			uic_pkg::REG_ISR_FCR: rdata = {{2{s_q.fen}}, code};
			default:              rdata = 8'h00;
		endcase
	end

	assign irq           = code != uic_pkg::CODE_NONE;
	assign fifo_en       = s_q.fen;
	assign dma_mode      = s_q.dma;
	assign sleep_en      = enh_en && s_q.ien[uic_pkg::IE_SLEEP];
	assign rx_fifo_reset = s_q.rxrst;
	assign tx_fifo_reset = s_q.txrst;
	assign rx_trigger    = rx_trig;
	assign tx_trigger    = tx_trig;
	// mode 0: single character; mode 1: trigger / fill based
	assign receive_ready_pin_n  = s_q.dma ? !(rx_src || tout) : (rx_count == 5'h00);
	assign transmit_ready_pin_n = s_q.dma ? (tx_count >= 5'(FIFO_DEPTH)) : !tx_empty;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_fcr_reset;
		wr_fcr && wdata[uic_pkg::FC_EN] && wdata[uic_pkg::FC_RXRST];
	endsequence

	a_bit0_idle: assert property (@(posedge clock) disable iff (!resetn)
		rdata[0] == !irq || addr != uic_pkg::REG_ISR_FCR) else $error("bit0 mismatch");
	a_fifo_bits: assert property (@(posedge clock) disable iff (!resetn)
		addr == uic_pkg::REG_ISR_FCR |-> rdata[7:6] == {2{fifo_en}}) else $error("fifo bits");
	a_rxrst_pulse: assert property (@(posedge clock) disable iff (!resetn)
		s_fcr_reset |=> rx_fifo_reset ##1 !rx_fifo_reset) else $error("rx reset pulse");
	a_txrst_pulse: assert property (@(posedge clock) disable iff (!resetn)
		wr_fcr && wdata[0] && wdata[2] |=> tx_fifo_reset ##1 !tx_fifo_reset) else $error("tx reset");
	a_fcr_ignored: assert property (@(posedge clock) disable iff (!resetn)
		wr_fcr && !wdata[0] |=> !rx_fifo_reset && $stable(dma_mode)) else $error("fcr ignored");
	a_line_top: assert property (@(posedge clock) disable iff (!resetn)
		line_act |-> code == uic_pkg::CODE_LINE) else $error("line priority");
	a_modem_clear: assert property (@(posedge clock) disable iff (!resetn)
		rd_msr && modem_delta == 4'h0 |=> !s_q.modem_p) else $error("modem clear");
	// a fresh below-trigger edge in the same cycle wins over the write
	a_tx_clear: assert property (@(posedge clock) disable iff (!resetn)
		wr_tx && !(tx_below && !s_q.tx_empty_prev) |=> !s_q.tx_p) else $error("tx clear");
	a_enh_gate: assert property (@(posedge clock) disable iff (!resetn)
		!enh_en |-> code != uic_pkg::CODE_XOFF && code != uic_pkg::CODE_FLOW) else $error("enh");
	a_dma_sel: assert property (@(posedge clock) disable iff (!resetn)
		wr_fcr && wdata[0] |=> dma_mode == $past(wdata[3])) else $error("dma select");

	// ------------------------------------------------------------
	// checks on sources and their clears
	// ------------------------------------------------------------
	sequence s_rts_rise;
		auto_rts && s_q.ien[uic_pkg::IE_RTS] && rts_out && !s_q.rts_prev;
	endsequence

	sequence s_cts_rise;
		auto_cts && s_q.ien[uic_pkg::IE_CTS] && cts_in && !s_q.cts_prev;
	endsequence

	a_rts_flow: assert property (@(posedge clock) disable iff (!resetn)
		s_rts_rise |=> s_q.flow_p) else $error("rts flow set");
	a_cts_flow: assert property (@(posedge clock) disable iff (!resetn)
		s_cts_rise |=> s_q.flow_p) else $error("cts flow set");
	a_overrun_set: assert property (@(posedge clock) disable iff (!resetn)
		overrun |=> s_q.line_p) else $error("overrun set");
	a_line_clear: assert property (@(posedge clock) disable iff (!resetn)
		rd_lsr && !overrun |=> !s_q.line_p) else $error("line clear");
	a_xoff_clear: assert property (@(posedge clock) disable iff (!resetn)
		(rd_isr || xon_seen) && !xoff_seen |=> !s_q.xoff_p) else $error("xoff clear");
	a_spec_clear: assert property (@(posedge clock) disable iff (!resetn)
		rx_char_in && s_q.spec_p && !special_seen |=> !s_q.spec_p) else $error("special clear");
	a_modem_set: assert property (@(posedge clock) disable iff (!resetn)
		|modem_delta |=> s_q.modem_p) else $error("modem set");
	a_ien_upper: assert property (@(posedge clock) disable iff (!resetn)
		wr_ien && !enh_en |=> s_q.ien[7:4] == $past(s_q.ien[7:4])) else $error("upper enables");
	a_tx_enable: assert property (@(posedge clock) disable iff (!resetn)
		wr_ien && wdata[1] && !s_q.ien[1] && tx_below |=> s_q.tx_p) else $error("tx enable");
	a_tout_code: assert property (@(posedge clock) disable iff (!resetn)
		tout_act && !line_act |-> code == uic_pkg::CODE_TOUT) else $error("time-out code");
	a_rx_ready: assert property (@(posedge clock) disable iff (!resetn)
		s_q.ien[uic_pkg::IE_RX] && s_q.fen && rx_count >= rx_trig && !line_act && !tout_act
		|-> code == uic_pkg::CODE_RECEIVE_READY_PIN) else $error("rx ready code");
	// irq must follow the enabled sources with no extra delay
	a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
		irq == (line_act || tout_act || rx_act || tx_act || modem_act || xoff_act || flow_act))
		else $error("irq level");
endmodule // uic_ctrl

// file: uic_host.sv
// host model: drives the parallel register port of one channel
`timescale 1ns/10ps
module uic_host (
	// clock
	input  wire logic       clock,
	// register port
	output logic      [2:0] addr,
	output logic            rd,
	output logic            wr,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata
);
	initial begin
		addr = 3'h0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 8'h00;
	end

	// strobe held one cycle, released at the edge that takes it
	task automatic write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		wdata <= ~d;
	endtask

	// rdata is combinational and stands while addr is held
	task automatic read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(negedge clock);
		d = rdata;
		@(posedge clock);
		rd <= 1'b0;
	endtask
endmodule // uic_host

// file: testbench.sv
// self-checking bench for the interrupt and fifo control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((e) !== (g)) begin mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic [2:0] addr;
	logic       rd, wr, irq, fifo_en, dma_mode, sleep_en, rx_fifo_reset, tx_fifo_reset;
	logic [7:0] wdata, rdata, d, v;
	logic       enh_en = 1'b0, auto_rts = 1'b0, auto_cts = 1'b0;
	logic       head_error = 1'b0, bit_tick = 1'b0, rxp_n, txp_n, fe = 1'b0;
	// one-cycle event inputs, one bit each
	localparam int P_OVR = 0, P_XOFF = 1, P_XON = 2, P_RTS = 3, P_CTS = 4, P_SPEC = 5, P_RXC = 6;
	logic [6:0] pls = 7'h00;
	wire        overrun = pls[P_OVR], xoff_seen = pls[P_XOFF], xon_seen = pls[P_XON];
	wire        rts_out = pls[P_RTS], cts_in = pls[P_CTS], special_seen = pls[P_SPEC];
	wire        rx_char_in = pls[P_RXC];
	logic [4:0] rx_count = 5'h00, tx_count = 5'h00, rx_trigger, tx_trigger;
	logic [3:0] modem_delta = 4'h0;
	int         mismatches = 0;
	int         n_compared = 0;

	always #5 clock = ~clock;

	uic_host u_host (.clock(clock), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
		.rdata(rdata));
	uic_ctrl u_uic_ctrl (.clock(clock), .resetn(resetn), .addr(addr), .rd(rd), .wr(wr),
		.wdata(wdata), .rdata(rdata), .enh_en(enh_en), .auto_rts(auto_rts),
		.auto_cts(auto_cts), .rx_count(rx_count), .rx_char_in(rx_char_in),
		.overrun(overrun), .head_error(head_error), .bit_tick(bit_tick),
		.char_bits(4'h8), .tx_count(tx_count), .modem_delta(modem_delta),
		.rts_out(rts_out), .cts_in(cts_in), .xoff_seen(xoff_seen), .xon_seen(xon_seen),
		.special_seen(special_seen), .irq(irq), .fifo_en(fifo_en), .dma_mode(dma_mode),
		.sleep_en(sleep_en), .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset),
		.rx_trigger(rx_trigger), .tx_trigger(tx_trigger), .receive_ready_pin_n(rxp_n),
		.transmit_ready_pin_n(txp_n));

	function automatic logic [4:0] exp_trig(input logic [1:0] s);
		logic [4:0] t[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
		return t[s];
	endfunction

	task automatic report_and_stop();
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// irq must agree with the pending flag, then the status byte is read
	task automatic check_status(input logic [5:0] code);
		logic [7:0] s;
		@(negedge clock);
		`CHK("irq", code != 6'h01, irq)
		u_host.read(uic_pkg::REG_ISR_FCR, s);
		`CHK("status", {fe, fe, code}, s)
	endtask

	task automatic fifo_control(input logic [7:0] val);
		u_host.write(uic_pkg::REG_ISR_FCR, val);
		if (val[0])
			fe = 1'b1;
		else
			fe = 1'b0;
	endtask

	task automatic pulse(input int k);
		@(posedge clock);
		pls[k] <= 1'b1;
		@(posedge clock);
		pls[k] <= 1'b0;
	endtask

	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		void'($urandom(38029));
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		u_host.read(uic_pkg::REG_IEN, d);
		`CHK("enable reset", 8'h00, d)
		check_status(6'h01);
		// -----------------------------------------------------------
		// fifo control: enable, self-clearing resets, ignored bits
		// -----------------------------------------------------------
		fifo_control(8'h07);
		@(negedge clock);
		`CHK("rx reset", 1'b1, rx_fifo_reset)
		`CHK("tx reset", 1'b1, tx_fifo_reset)
		@(negedge clock);
		`CHK("rx reset end", 1'b0, rx_fifo_reset)
		`CHK("tx reset end", 1'b0, tx_fifo_reset)
		check_status(6'h01);
		fifo_control(8'h0E);
		@(negedge clock);
		`CHK("fifo off", 1'b0, fifo_en)
		`CHK("reset ignored", 1'b0, rx_fifo_reset | dma_mode)
		check_status(6'h01);
		fifo_control(8'h09);
		enh_en <= 1'b1;
		@(negedge clock);
		`CHK("dma", 1'b1, dma_mode)
		`CHK("rx pin dma", 1'b1, rxp_n)
		`CHK("tx pin dma", 1'b0, txp_n)
		for (int s = 0; s < 4; s++) begin
			fifo_control({s[1:0], s[1:0], 4'h1});
			@(negedge clock);
			`CHK("rx trig", exp_trig(s[1:0]), rx_trigger)
			`CHK("tx trig", exp_trig(s[1:0]), tx_trigger)
		end
		@(posedge clock);
		enh_en <= 1'b0;
		fifo_control(8'h01);
		@(negedge clock);
		`CHK("tx trig held", exp_trig(2'h3), tx_trigger)
		`CHK("rx trig", exp_trig(2'h0), rx_trigger)
		// -----------------------------------------------------------
		// priority walk: transmit, data ready, line, time-out
		// -----------------------------------------------------------
		u_host.write(uic_pkg::REG_IEN, 8'h07);
		check_status(6'h02);
		u_host.write(uic_pkg::REG_IEN, 8'h05);
		u_host.write(uic_pkg::REG_IEN, 8'h07);
		rx_count <= 5'h01;
		check_status(6'h04);
		`CHK("rx ready pin", 1'b0, rxp_n)
		pulse(P_OVR);
		check_status(6'h06);
		u_host.read(uic_pkg::REG_LSR, d);
		check_status(6'h04);
		bit_tick <= 1'b1;
		repeat (20) @(posedge clock);
		check_status(6'h04);
		repeat (40) @(posedge clock);
		check_status(6'h0C);
		head_error <= 1'b1;
		u_host.read(uic_pkg::REG_RX_TX, d);
		head_error <= 1'b0;
		bit_tick <= 1'b0;
		rx_count <= 5'h00;
		check_status(6'h06);
		u_host.read(uic_pkg::REG_LSR, d);
		check_status(6'h02);
		check_status(6'h01);
		u_host.write(uic_pkg::REG_IEN, 8'h00);
		u_host.write(uic_pkg::REG_IEN, 8'h02);
		check_status(6'h02);
		u_host.write(uic_pkg::REG_RX_TX, 8'h5A);
		check_status(6'h01);
		tx_count <= 5'h0F;
		@(posedge clock);
		tx_count <= 5'h0D;
		@(posedge clock);
		check_status(6'h02);
		`CHK("tx ready pin", 1'b1, txp_n)
		tx_count <= 5'h00;
		// -----------------------------------------------------------
		// modem, software and hardware flow sources
		// -----------------------------------------------------------
		u_host.write(uic_pkg::REG_IEN, 8'hF8);
		pulse(P_XOFF);
		@(posedge clock);
		modem_delta <= 4'h4;
		@(posedge clock);
		modem_delta <= 4'h0;
		check_status(6'h00);
		u_host.read(uic_pkg::REG_MSR, d);
		check_status(6'h01);
		enh_en <= 1'b1;
		auto_rts <= 1'b1;
		u_host.write(uic_pkg::REG_IEN, 8'hE0);
		pulse(P_XOFF);
		check_status(6'h10);
		check_status(6'h01);
		pulse(P_XOFF);
		pulse(P_XON);
		check_status(6'h01);
		pulse(P_SPEC);
		check_status(6'h10);
		pulse(P_SPEC);
		pulse(P_RXC);
		check_status(6'h01);
		pulse(P_RTS);
		check_status(6'h20);
		u_host.read(uic_pkg::REG_MSR, d);
		check_status(6'h01);
		auto_cts <= 1'b1;
		pulse(P_CTS);
		check_status(6'h20);
		u_host.read(uic_pkg::REG_MSR, d);
		check_status(6'h01);
		// -----------------------------------------------------------
		// random enable values read back
		// -----------------------------------------------------------
		repeat (8) begin
			v = 8'($urandom);
			u_host.write(uic_pkg::REG_IEN, v);
			u_host.read(uic_pkg::REG_IEN, d);
			`CHK("enable readback", v, d)
			`CHK("sleep", v[4], sleep_en)
			u_host.write(uic_pkg::REG_IEN, 8'h00);
			u_host.read(uic_pkg::REG_MSR, d);
		end
		report_and_stop();
	end
endmodule // testbench
